// File: trigger_control_timestamp_regs.svh
// constants for the central trigger control and timestamp block
// Overview of operation
// - common clock reaches front-ends; device follows it
// - 48-bit global clock counter, one per cycle
// - 16-bit event counter counts delivered accepts
// - accept only when every receiver can take it
// - state machine models derandomizer occupancy per accept
// - predicted overflow suppresses the new accept
// - model is FIFO with whole-cycle latencies
// - one accept decision per common clock cycle
// - optional limit of accepts per window
// - request pattern gives multiplicity or coincidence validation
// - almost-full warnings accepted, delayed microseconds
// - front-end error reports recorded for action
// - request to decision latency fixed, pipeline depth
`ifndef TRIGGER_CONTROL_TIMESTAMP_REGS_SVH
`define TRIGGER_CONTROL_TIMESTAMP_REGS_SVH
`define N_CRYSTAL 8
`define CLOCK_COUNT_W 48
`define EVENT_COUNT_W 16
`define PIPE_DEPTH 4
`define WRITE_LAT 4'h2
`define HIST_LEN 64
`define WIN_W 6
`define RULE_W 4
`define DEPTH_W 4
`define SERVICE_W 8
`endif

// File: trigger_control_pkg.sv
// types for the central trigger control and timestamp block
`default_nettype none
package trigger_control_pkg;
  typedef enum logic [1:0] {
    derand_empty = 2'b00,
    derand_serve = 2'b01,
    derand_full = 2'b11
  } derand_state_type;
endpackage : trigger_control_pkg
`default_nettype wire

// File: trigger_rule_window.sv
// sliding window count of accepts for the trigger-rule check
`timescale 1ns/1ps
`default_nettype none
`include "trigger_control_timestamp_regs.svh"
module trigger_rule_window (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_tick,
  input wire logic i_accept,
  input wire logic [`RULE_W-1:0] i_limit,
  input wire logic [`WIN_W-1:0] i_window,
  output logic o_room
);
  logic [`HIST_LEN-1:0] history;
  logic [`HIST_LEN-1:0] next_history;
  logic [`WIN_W-1:0] span;

  // accepts among the newest span entries; recounted so a window change never leaves a stale total
  function automatic logic [`WIN_W:0] count_recent(input logic [`HIST_LEN-1:0] bits,
    input logic [`WIN_W-1:0] limit_span);
    logic [`WIN_W:0] total;
    total = '0;
    for (int i = 0; i < `HIST_LEN; i++) begin
      if (i < limit_span) begin
        total = total + {{`WIN_W{1'b0}}, bits[i]};
      end
    end
    return total;
  endfunction : count_recent

  // newest accept enters at the bottom; the next cycle itself takes one slot of the window
  always_comb begin
    next_history = {history[`HIST_LEN-2:0], i_accept};
    span = i_window - {{(`WIN_W-1){1'b0}}, 1'b1};
  end

  // history advances once per global cycle; room is judged for the next cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      history <= '0;
      o_room <= 1'b1;
    end else if (i_tick) begin
      history <= next_history;
      // a zero limit or a zero window switches the rule off
      o_room <= (i_limit == '0) || (i_window == '0) ||
        (count_recent(next_history, span) < {{(`WIN_W+1-`RULE_W){1'b0}}, i_limit});
    end
  end
endmodule : trigger_rule_window
`default_nettype wire

// File: trigger_control_timestamp.sv
// central trigger control, derandomizer throttle and timestamp counters
`timescale 1ns/1ps
`default_nettype none
`include "trigger_control_timestamp_regs.svh"
module trigger_control_timestamp (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic [`N_CRYSTAL-1:0] i_trig_req,
  input wire logic [`N_CRYSTAL-1:0] i_almost_full,
  input wire logic [`N_CRYSTAL-1:0] i_fault,
  input wire logic i_ancillary,
  input wire logic i_coinc_mode,
  input wire logic [3:0] i_mult_threshold,
  input wire logic [`DEPTH_W-1:0] i_derand_depth,
  input wire logic [`SERVICE_W-1:0] i_service_time,
  input wire logic [`RULE_W-1:0] i_rule_limit,
  input wire logic [`WIN_W-1:0] i_rule_window,
  input wire logic i_report_clear,
  output logic o_first_level_accept,
  output logic o_throttled,
  output logic [`CLOCK_COUNT_W-1:0] o_clock_count,
  output logic [`EVENT_COUNT_W-1:0] o_event_count,
  output logic [`N_CRYSTAL-1:0] o_warning_flags,
  output logic [`N_CRYSTAL-1:0] o_error_flags,
  output logic o_derand_busy
);
  // two-flop synchronisers for everything arriving from the link
  logic link_meta;
  logic link_sync;
  logic link_prev;
  logic [`N_CRYSTAL-1:0] req_meta;
  logic [`N_CRYSTAL-1:0] req_sync;
  logic [`N_CRYSTAL-1:0] full_meta;
  logic [`N_CRYSTAL-1:0] full_sync;
  logic [`N_CRYSTAL-1:0] fault_meta;
  logic [`N_CRYSTAL-1:0] fault_sync;
  logic anc_meta;
  logic anc_sync;
  logic tick;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      link_meta <= 1'b0;
      link_sync <= 1'b0;
      link_prev <= 1'b0;
      req_meta <= '0;
      req_sync <= '0;
      full_meta <= '0;
      full_sync <= '0;
      fault_meta <= '0;
      fault_sync <= '0;
      anc_meta <= 1'b0;
      anc_sync <= 1'b0;
    end else begin
      link_meta <= i_link_clk;
      link_sync <= link_meta;
      link_prev <= link_sync;
      req_meta <= i_trig_req;
      req_sync <= req_meta;
      full_meta <= i_almost_full;
      full_sync <= full_meta;
      fault_meta <= i_fault;
      fault_sync <= fault_meta;
      anc_meta <= i_ancillary;
      anc_sync <= anc_meta;
    end
  end

  // each rising edge of the common clock marks one global cycle
  assign tick = link_sync & ~link_prev;

  // population count of the request pattern
  function automatic logic [3:0] count_ones(input logic [`N_CRYSTAL-1:0] pattern);
    logic [3:0] total;
    total = 4'h0;
    for (int i = 0; i < `N_CRYSTAL; i++) begin
      total = total + {3'b000, pattern[i]};
    end
    return total;
  endfunction : count_ones

  // validation from multiplicity, optionally in coincidence with ancillary
  logic validation;
  logic [`PIPE_DEPTH-1:0] valid_pipe;
  assign validation = (count_ones(req_sync) >= i_mult_threshold) &&
    (count_ones(req_sync) != 4'h0) && (!i_coinc_mode || anc_sync);

  // fixed latency from request pattern to decision
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      valid_pipe <= '0;
    end else if (tick) begin
      valid_pipe <= {valid_pipe[`PIPE_DEPTH-2:0], validation};
    end
  end

  // derandomizer emulation
  trigger_control_pkg::derand_state_type state;
  logic [`DEPTH_W:0] occupancy;
  logic [`SERVICE_W:0] service_left;
  logic [`DEPTH_W:0] next_occupancy;
  logic read_done;
  logic candidate;
  logic rule_room;
  logic any_warning;
  logic grant;

  // pipe head, any live warning, and the read of the head entry
  assign candidate = valid_pipe[`PIPE_DEPTH-1];
  assign any_warning = |full_sync;
  assign read_done = (occupancy != '0) && (service_left == '0);

  // grant only if the modelled queue still has room after this cycle's read
  always_comb begin
    next_occupancy = occupancy - {{`DEPTH_W{1'b0}}, read_done};
    grant = candidate && rule_room && !any_warning &&
      (next_occupancy < {1'b0, i_derand_depth});
    if (grant) begin
      next_occupancy = next_occupancy + {{`DEPTH_W{1'b0}}, 1'b1};
    end
  end

  // occupancy of the modelled queue, advanced per global cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      occupancy <= '0;
    end else if (tick) begin
      occupancy <= next_occupancy;
    end
  end

  // entry into an empty queue waits write latency then service time, a later head service time only, all whole cycles
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      service_left <= '0;
    end else if (tick) begin
      if (occupancy == '0 && grant) begin
        service_left <= {1'b0, i_service_time} + {5'h00, `WRITE_LAT};
      end else if (read_done && next_occupancy != '0) begin
        service_left <= {1'b0, i_service_time};
      end else if (service_left != '0) begin
        service_left <= service_left - {{`SERVICE_W{1'b0}}, 1'b1};
      end
    end
  end

  // model state: empty, serving, or full at the configured depth
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= trigger_control_pkg::derand_empty;
    end else if (tick) begin
      case (state)
        trigger_control_pkg::derand_empty: begin
          if (next_occupancy != '0) begin
            state <= trigger_control_pkg::derand_serve;
          end
        end
        trigger_control_pkg::derand_serve: begin
          if (next_occupancy == '0) begin
            state <= trigger_control_pkg::derand_empty;
          end else if (next_occupancy >= {1'b0, i_derand_depth}) begin
            state <= trigger_control_pkg::derand_full;
          end
        end
        default: begin
          if (next_occupancy < {1'b0, i_derand_depth}) begin
            state <= trigger_control_pkg::derand_serve;
          end
        end
      endcase
    end
  end

  trigger_rule_window u_rule (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_tick(tick),
    .i_accept(grant),
    .i_limit(i_rule_limit),
    .i_window(i_rule_window),
    .o_room(rule_room)
  );

  // accept and throttle pulses, one i_clk cycle per global cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_first_level_accept <= 1'b0;
      o_throttled <= 1'b0;
      o_derand_busy <= 1'b0;
    end else begin
      o_first_level_accept <= tick && grant;
      o_throttled <= tick && candidate && !grant;
      o_derand_busy <= (state == trigger_control_pkg::derand_full);
    end
  end

  // timestamp counters
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_clock_count <= '0;
      o_event_count <= '0;
    end else if (tick) begin
      o_clock_count <= o_clock_count + {{(`CLOCK_COUNT_W-1){1'b0}}, 1'b1};
      if (grant) begin
        o_event_count <= o_event_count + {{(`EVENT_COUNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // sticky warning and error records per crystal; a new report beats the clear
  genvar g;
  generate
    for (g = 0; g < `N_CRYSTAL; g = g + 1) begin : g_record
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          o_warning_flags[g] <= 1'b0;
          o_error_flags[g] <= 1'b0;
        end else begin
          o_warning_flags[g] <= (o_warning_flags[g] && !i_report_clear) || full_sync[g];
          o_error_flags[g] <= (o_error_flags[g] && !i_report_clear) || fault_sync[g];
        end
      end
    end
  endgenerate
endmodule : trigger_control_timestamp
`default_nettype wire

// File: trigger_control_timestamp_assertions.sv
// checker for the trigger control and timestamp outputs
`timescale 1ns/1ps
`default_nettype none
module trigger_control_timestamp_assertions (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_almost_full,
  input wire logic [7:0] i_fault,
  input wire logic [3:0] i_derand_depth,
  input wire logic o_first_level_accept,
  input wire logic o_throttled,
  input wire logic [47:0] o_clock_count,
  input wire logic [15:0] o_event_count,
  input wire logic [7:0] o_warning_flags,
  input wire logic [7:0] o_error_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // cycles since reset release, saturating at 7
  logic [2:0] up;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  accept_pulse_a: assert property (o_first_level_accept |=> !o_first_level_accept)
    else $error("accept wider than one cycle");
  accept_excl_a: assert property (!(o_first_level_accept && o_throttled))
    else $error("accept and throttle together");
  event_step_a: assert property (up == 3'h7 |->
    o_event_count == $past(o_event_count) + {15'h0, o_first_level_accept})
    else $error("event count off");
  clock_step_a: assert property (up == 3'h7 && $changed(o_clock_count) |->
    o_clock_count == $past(o_clock_count) + 48'h1) else $error("clock count jump");
  clock_gap_a: assert property (up == 3'h7 && $changed(o_clock_count) |=> $stable(o_clock_count))
    else $error("clock count too fast");
  warn_block_a: assert property ((i_almost_full != 8'h00)[*4] |-> !o_first_level_accept)
    else $error("accept under warning");
  warn_flag_a: assert property (up == 3'h7 |->
    &(o_warning_flags | ~($past(i_almost_full, 2) & $past(i_almost_full, 3) & $past(i_almost_full, 4))))
    else $error("warning not recorded");
  error_flag_a: assert property (up == 3'h7 |->
    &(o_error_flags | ~($past(i_fault, 2) & $past(i_fault, 3) & $past(i_fault, 4))))
    else $error("error not recorded");
  depth_zero_a: assert property ((i_derand_depth == 4'h0)[*2] |-> !o_first_level_accept)
    else $error("accept with zero depth");
  cover property (o_first_level_accept);
  cover property (o_throttled);
  cover property (o_error_flags != 8'h00);
endmodule : trigger_control_timestamp_assertions
bind trigger_control_timestamp trigger_control_timestamp_assertions chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_almost_full(i_almost_full), .i_fault(i_fault), .i_derand_depth(i_derand_depth),
  .o_first_level_accept(o_first_level_accept), .o_throttled(o_throttled), .o_clock_count(o_clock_count),
  .o_event_count(o_event_count), .o_warning_flags(o_warning_flags), .o_error_flags(o_error_flags));
`default_nettype wire

// File: crystal_frontend_model.sv
// crystal front-end model: trigger requests, warnings, faults
`timescale 1ns/1ps
`default_nettype none
module crystal_frontend_model (
  input wire logic i_link_clk,
  input wire logic i_arm,
  input wire logic [3:0] i_hits,
  input wire logic [7:0] i_hit,
  input wire logic [7:0] i_fill,
  input wire logic [7:0] i_bad,
  output logic [7:0] o_trig_req = 8'h00,
  output logic [7:0] o_almost_full = 8'h00,
  output logic [7:0] o_fault = 8'h00
);
  logic armed = 1'b0;
  logic [3:0] left = 4'h0;
  // launch mid link period, one link cycle per hit
  always @(negedge i_link_clk) begin
    armed <= i_arm;
    o_trig_req <= (left != 4'h0) ? i_hit : 8'h00;
    o_almost_full <= i_fill;
    o_fault <= i_bad;
    if (i_arm && !armed) left <= i_hits;
    else if (left != 4'h0) left <= left - 4'h1;
  end
endmodule : crystal_frontend_model
`default_nettype wire

// File: test_trigger_control_timestamp.sv
// testbench for the trigger control and timestamp block
`timescale 1ns/1ps
`default_nettype none
module test_trigger_control_timestamp;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, i_link_clk = 1'b0, arm = 1'b0;
  logic i_ancillary = 1'b0, i_coinc_mode = 1'b0, i_report_clear = 1'b0;
  logic [3:0] hits = 4'h0, i_mult_threshold = 4'h2, i_derand_depth = 4'h4, i_rule_limit = 4'h0;
  logic [5:0] i_rule_window = 6'h00;
  logic [7:0] i_service_time = 8'h00, hit = 8'h00, fill = 8'h00, bad = 8'h00;
  wire logic [7:0] i_trig_req, i_almost_full, i_fault, o_warning_flags, o_error_flags;
  wire logic o_first_level_accept, o_throttled, o_derand_busy;
  wire logic [47:0] o_clock_count;
  wire logic [15:0] o_event_count;
  int bad_count = 0, n_tests = 0, na = 0, nt = 0;
  always #25 i_clk = ~i_clk;
  // link clock, phase unrelated to i_clk
  initial #7 forever #200 i_link_clk = ~i_link_clk;
  // count decision pulses
  always @(posedge i_clk) begin
    if (o_first_level_accept === 1'b1) na++;
    if (o_throttled === 1'b1) nt++;
  end
  crystal_frontend_model fe_u (.i_link_clk(i_link_clk), .i_arm(arm), .i_hits(hits), .i_hit(hit),
    .i_fill(fill), .i_bad(bad), .o_trig_req(i_trig_req), .o_almost_full(i_almost_full), .o_fault(i_fault));
  trigger_control_timestamp dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
    .i_trig_req(i_trig_req), .i_almost_full(i_almost_full), .i_fault(i_fault), .i_ancillary(i_ancillary),
    .i_coinc_mode(i_coinc_mode), .i_mult_threshold(i_mult_threshold), .i_derand_depth(i_derand_depth),
    .i_service_time(i_service_time), .i_rule_limit(i_rule_limit), .i_rule_window(i_rule_window),
    .i_report_clear(i_report_clear), .o_first_level_accept(o_first_level_accept), .o_throttled(o_throttled),
    .o_clock_count(o_clock_count), .o_event_count(o_event_count), .o_warning_flags(o_warning_flags),
    .o_error_flags(o_error_flags), .o_derand_busy(o_derand_busy));
  task automatic check(string what, logic [47:0] exp, logic [47:0] got);
    n_tests++;
    if (exp !== got) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // n link cycles of request pattern p, then count accepts and throttles
  task automatic fire(logic [7:0] p, logic [3:0] n, int ea, int et);
    logic [15:0] e0;
    int a0;
    int t0;
    @(negedge i_clk);
    e0 = o_event_count;
    a0 = na;
    t0 = nt;
    @(posedge i_clk);
    hit <= p;
    hits <= n;
    arm <= 1'b1;
    repeat (8 * (n + 10)) @(posedge i_clk);
    arm <= 1'b0;
    repeat (10) @(posedge i_clk);
    check("accepts", ea, na - a0);
    check("throttles", et, nt - t0);
    check("event count", e0 + ea, o_event_count);
  endtask : fire
  task automatic t_clock;
    logic [47:0] c0;
    @(posedge i_link_clk);
    repeat (2) @(posedge i_clk);
    c0 = o_clock_count;
    repeat (10) @(posedge i_link_clk);
    repeat (2) @(posedge i_clk);
    check("clock count", c0 + 48'hA, o_clock_count);
  endtask : t_clock
  task automatic t_mult;
    fire(8'h01, 4'h1, 0, 0);
    fire(8'h03, 4'h1, 1, 0);
    i_coinc_mode <= 1'b1;
    fire(8'h03, 4'h1, 0, 0);
    i_ancillary <= 1'b1;
    fire(8'h03, 4'h1, 1, 0);
    i_coinc_mode <= 1'b0;
  endtask : t_mult
  task automatic t_derand;
    i_derand_depth <= 4'h0;
    fire(8'h03, 4'h1, 0, 1);
    i_derand_depth <= 4'h1;
    i_service_time <= 8'h14;
    fire(8'h03, 4'h2, 1, 1);
    check("derand busy", 1'b1, o_derand_busy);
    i_derand_depth <= 4'h8;
    i_service_time <= 8'h00;
    repeat (240) @(posedge i_clk);
    check("derand idle", 1'b0, o_derand_busy);
  endtask : t_derand
  task automatic t_rule;
    i_rule_limit <= 4'h2;
    i_rule_window <= 6'h14;
    fire(8'h03, 4'h4, 2, 2);
    i_rule_limit <= 4'h0;
  endtask : t_rule
  task automatic t_flags;
    fill <= 8'h01;
    bad <= 8'h80;
    repeat (16) @(posedge i_clk);
    fire(8'h03, 4'h1, 0, 1);
    check("warnings", 8'h01, o_warning_flags);
    check("errors", 8'h80, o_error_flags);
    fill <= 8'h00;
    bad <= 8'h00;
    repeat (16) @(posedge i_clk);
    i_report_clear <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_report_clear <= 1'b0;
    @(posedge i_clk);
    check("cleared", 16'h0, {o_warning_flags, o_error_flags});
  endtask : t_flags
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (10) @(posedge i_clk);
    t_clock();
    t_mult();
    t_derand();
    t_rule();
    t_flags();
    finish_test();
  end
  // watchdog well past the expected run length
  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end
endmodule : test_trigger_control_timestamp
`default_nettype wire
